// >>> design/qfsb_pkg.sv
// Constants, types and decoders shared by the queue flag status bus ends.
// Assumes one clock, mclk_in at 25 MHz, with a synchronous active low reset.
//
// Notes on behaviour
// - Flag mode low at reset: direct; high: polled.
// - Direct full side: strobe plus two address bits.
// - Full bus shows new quadrant one cycle later.
// - Quadrant code picks eight queues, bit per queue.
// - Bits of unconfigured queues are don't care.
// - Switching-cycle access may settle one cycle late.
// - Controller never strobes with write queue select.
// - Eight or fewer queues, direct mode: queues 0-7 always shown.
// - Top three write address bits select device.
// - Polled full bus advances quadrant every edge.
// - Master starts after reset; others release bus.
// - Sync mark high during own first quadrant.
// - Hold four quadrants, passing token onward during the last.
// - Single device loops token output to input.
// - Empty bus shared by mode when nine queues.
// - Direct empty side: strobe, capture, update next.
// - Read side quadrant codes map like write side.
// - Read side switching access may lag a cycle.
// - Controller never strobes with read queue select.
// - Top three read address bits select device.
// - Small single systems should prefer polled mode.
// - Polled empty bus: quadrant per edge, sync, token.

package qfsb_pkg;

	// ----------------------------------------------------------------
	// Sizes and field positions
	// ----------------------------------------------------------------
	localparam int QFSB_NUM_QUEUES = 32;
	localparam int QFSB_BUS_W = 8;
	localparam int QFSB_QUAD_W = 2;
	localparam int QFSB_ID_W = 3;
	localparam int QFSB_WR_ADDR_W = 8;
	localparam int QFSB_RD_ADDR_W = 7;
	localparam int QFSB_QUAD_LSB = 0;
	localparam int QFSB_WR_ID_LSB = 5;
	localparam int QFSB_RD_ID_LSB = 4;
	localparam int QFSB_SIDES = 2;
	localparam int QFSB_SIDE_FULL = 0;
	localparam int QFSB_SIDE_EMPTY = 1;
	localparam int QFSB_STRAP_W = 6;

	// ----------------------------------------------------------------
	// Reset and idle values
	// ----------------------------------------------------------------
	localparam logic QFSB_MODE_DIRECT = 1'b0;
	localparam logic QFSB_MODE_POLLED = 1'b1;
	localparam logic [1:0] QFSB_QUAD_RST = 2'h0;
	localparam logic [1:0] QFSB_QUAD_LAST = 2'h3;
	localparam logic [7:0] QFSB_BUS_IDLE = 8'hff;
	localparam logic [5:0] QFSB_STRAP_RST = 6'h00;

	// ----------------------------------------------------------------
	// Polled sequence, Gray coded along the quadrant walk
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		QFSB_ST_IDLE = 3'h0,
		QFSB_ST_Q0 = 3'h1,
		QFSB_ST_Q1 = 3'h3,
		QFSB_ST_Q2 = 3'h2,
		QFSB_ST_Q3 = 3'h6
	} qfsb_poll_e;

	function automatic logic [1:0] qfsb_quad_of(input qfsb_poll_e st);
		case (st)
			QFSB_ST_Q1: qfsb_quad_of = 2'h1;
			QFSB_ST_Q2: qfsb_quad_of = 2'h2;
			QFSB_ST_Q3: qfsb_quad_of = 2'h3;
			default: qfsb_quad_of = 2'h0;
		endcase
	endfunction

	function automatic logic [7:0] qfsb_slice(input logic [31:0] status, input logic [1:0] quad);
		qfsb_slice = status[{quad, 3'h0} +: 8];
	endfunction

endpackage

// >>> design/qfsb_if.sv
// Wires between one flag status device and its controller.
// Assumes a single device: the board loop of each token is made here.

interface qfsb_if;
	import qfsb_pkg::*;

	logic [7:0] wr_addr;
	logic af_strobe;
	logic [6:0] rd_addr;
	logic ae_strobe;
	logic [7:0] af_bus_d;
	logic af_bus_oe;
	logic af_sync;
	logic af_token_out;
	logic af_token_in;
	logic [7:0] ae_bus_d;
	logic ae_bus_oe;
	logic ae_sync;
	logic ae_token_out;
	logic ae_token_in;
	logic [7:0] af_bus;
	logic [7:0] ae_bus;

	// Released bus floats high through pull-ups
	assign af_bus = af_bus_oe ? af_bus_d : QFSB_BUS_IDLE;
	assign ae_bus = ae_bus_oe ? ae_bus_d : QFSB_BUS_IDLE;
	// Single device token loops
	assign af_token_in = af_token_out;
	assign ae_token_in = ae_token_out;

	modport device_mp (
		input wr_addr, af_strobe, rd_addr, ae_strobe, af_token_in, ae_token_in,
		output af_bus_d, af_bus_oe, af_sync, af_token_out,
		output ae_bus_d, ae_bus_oe, ae_sync, ae_token_out
	);

	modport ctrl_mp (
		output wr_addr, af_strobe, rd_addr, ae_strobe,
		input af_bus, af_bus_oe, af_sync, ae_bus, ae_bus_oe, ae_sync
	);

endinterface

// >>> design/qfsb_device.sv
// Flag status bus end of the queue device: almost-full and
// almost-empty/packet-ready buses, direct or polled.
// Assumes queue status vectors from the flag logic on the same clock and
// static straps, held steady through at least four reset edges.

module qfsb_device import qfsb_pkg::*; (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic flag_bus_mode_select_in,
	input wire logic chain_master_strap_in,
	input wire logic device_identifier_bit0_in,
	input wire logic device_identifier_bit1_in,
	input wire logic device_identifier_bit2_in,
	input wire logic eight_or_fewer_queues_in,
	input wire logic [31:0] almost_full_status_in,
	input wire logic [31:0] almost_empty_status_in,
	output logic polled_mode_out,
	output logic [1:0] full_quadrant_out,
	output logic [1:0] empty_quadrant_out,
	qfsb_if.device_mp link
);

	// ----------------------------------------------------------------
	// Strap synchronisers
	// ----------------------------------------------------------------
	logic [5:0] strap_raw;
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic [5:0] sync3_reg;
	logic [5:0] strap_reg;
	logic [5:0] sync1_next;
	logic [5:0] sync2_next;
	logic [5:0] sync3_next;
	logic [5:0] strap_next;
	logic [5:0] strap_now;

	assign strap_raw = {eight_or_fewer_queues_in, device_identifier_bit2_in,
		device_identifier_bit1_in, device_identifier_bit0_in,
		chain_master_strap_in, flag_bus_mode_select_in};

	// Chain runs through reset so straps settle before the last reset edge
	always_comb begin
		sync1_next = strap_raw;
		sync2_next = sync1_reg;
		sync3_next = sync2_reg;
		strap_now = strap_reg;
		if (sync2_reg == sync3_reg) begin
			strap_now = sync3_reg;
		end
		strap_next = strap_now;
	end

	always_ff @(posedge mclk_in) begin
		sync1_reg <= sync1_next;
		sync2_reg <= sync2_next;
		sync3_reg <= sync3_next;
		strap_reg <= strap_next;
	end

	logic strap_mode;
	logic strap_master;
	logic [2:0] strap_id;
	logic strap_small;

	assign strap_mode = strap_now[0];
	assign strap_master = strap_now[1];
	assign strap_id = strap_now[4:2];
	assign strap_small = strap_now[5];

	// ----------------------------------------------------------------
	// Bus mode, caught while master reset is held
	// ----------------------------------------------------------------
	logic mode_reg;
	logic mode_next;
	logic small_reg;
	logic small_next;

	always_comb begin
		mode_next = mode_reg;
		small_next = small_reg;
		if (!resetn_in) begin
			mode_next = strap_mode;
			small_next = strap_small;
		end
	end

	always_ff @(posedge mclk_in) begin
		mode_reg <= mode_next;
		small_reg <= small_next;
	end

	// ----------------------------------------------------------------
	// Per side views of the link
	// ----------------------------------------------------------------
	logic [1:0] sel_quad [QFSB_SIDES];
	logic [2:0] sel_id [QFSB_SIDES];
	logic sel_strobe [QFSB_SIDES];
	logic token_in [QFSB_SIDES];
	logic [31:0] side_status [QFSB_SIDES];

	always_comb begin
		sel_quad[QFSB_SIDE_FULL] = link.wr_addr[QFSB_QUAD_LSB +: QFSB_QUAD_W];
		sel_id[QFSB_SIDE_FULL] = link.wr_addr[QFSB_WR_ID_LSB +: QFSB_ID_W];
		sel_strobe[QFSB_SIDE_FULL] = link.af_strobe;
		token_in[QFSB_SIDE_FULL] = link.af_token_in;
		side_status[QFSB_SIDE_FULL] = almost_full_status_in;
		sel_quad[QFSB_SIDE_EMPTY] = link.rd_addr[QFSB_QUAD_LSB +: QFSB_QUAD_W];
		sel_id[QFSB_SIDE_EMPTY] = link.rd_addr[QFSB_RD_ID_LSB +: QFSB_ID_W];
		sel_strobe[QFSB_SIDE_EMPTY] = link.ae_strobe;
		token_in[QFSB_SIDE_EMPTY] = link.ae_token_in;
		side_status[QFSB_SIDE_EMPTY] = almost_empty_status_in;
	end

	// ----------------------------------------------------------------
	// Quadrant engines, one per bus
	// ----------------------------------------------------------------
	qfsb_poll_e st_reg [QFSB_SIDES];
	logic [1:0] quad_reg [QFSB_SIDES];
	logic [7:0] data_reg [QFSB_SIDES];
	logic oe_reg [QFSB_SIDES];
	logic sync_reg [QFSB_SIDES];
	logic token_reg [QFSB_SIDES];
	logic launch_reg [QFSB_SIDES];

	genvar s;
	generate
		for (s = 0; s < QFSB_SIDES; s++) begin : g_side
			qfsb_poll_e st_next;
			logic [1:0] quad_next;
			logic [7:0] data_next;
			logic oe_next;
			logic sync_next;
			logic token_next;
			logic launch_next;

			always_comb begin
				st_next = st_reg[s];
				quad_next = quad_reg[s];
				oe_next = oe_reg[s];
				sync_next = 1'b0;
				token_next = 1'b0;
				launch_next = launch_reg[s];
				if (!resetn_in) begin
					st_next = QFSB_ST_IDLE;
					quad_next = QFSB_QUAD_RST;
					oe_next = 1'b0;
					launch_next = strap_master;
				end else if (mode_reg == QFSB_MODE_DIRECT) begin
					st_next = QFSB_ST_IDLE;
					if (small_reg) begin
						quad_next = QFSB_QUAD_RST;
						oe_next = 1'b1;
					end else if (sel_strobe[s]) begin
						if (sel_id[s] == strap_id) begin
							quad_next = sel_quad[s];
							oe_next = 1'b1;
						end else begin
							// Another device owns the bus; keep our quadrant
							oe_next = 1'b0;
						end
					end
				end else begin
					case (st_reg[s])
						QFSB_ST_IDLE: begin
							if (launch_reg[s] || token_in[s]) begin
								st_next = QFSB_ST_Q0;
								launch_next = 1'b0;
							end
						end
						QFSB_ST_Q0: st_next = QFSB_ST_Q1;
						QFSB_ST_Q1: st_next = QFSB_ST_Q2;
						QFSB_ST_Q2: st_next = QFSB_ST_Q3;
						QFSB_ST_Q3: begin
							// Own token returned: lap again without a gap
							st_next = token_in[s] ? QFSB_ST_Q0 : QFSB_ST_IDLE;
						end
						default: st_next = QFSB_ST_IDLE;
					endcase
					quad_next = qfsb_quad_of(st_next);
					oe_next = (st_next != QFSB_ST_IDLE);
					sync_next = (st_next == QFSB_ST_Q0);
					token_next = (st_next == QFSB_ST_Q3);
				end
				// Status keeps tracking the held quadrant every cycle;
				// a queue touched on the switch edge catches up next cycle
				data_next = qfsb_slice(side_status[s], quad_next);
			end

			always_ff @(posedge mclk_in) begin
				st_reg[s] <= st_next;
				quad_reg[s] <= quad_next;
				data_reg[s] <= data_next;
				oe_reg[s] <= oe_next;
				sync_reg[s] <= sync_next;
				token_reg[s] <= token_next;
				launch_reg[s] <= launch_next;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign link.af_bus_d = data_reg[QFSB_SIDE_FULL];
	assign link.af_bus_oe = oe_reg[QFSB_SIDE_FULL];
	assign link.af_sync = sync_reg[QFSB_SIDE_FULL];
	assign link.af_token_out = token_reg[QFSB_SIDE_FULL];
	assign link.ae_bus_d = data_reg[QFSB_SIDE_EMPTY];
	assign link.ae_bus_oe = oe_reg[QFSB_SIDE_EMPTY];
	assign link.ae_sync = sync_reg[QFSB_SIDE_EMPTY];
	assign link.ae_token_out = token_reg[QFSB_SIDE_EMPTY];
	assign polled_mode_out = mode_reg;
	assign full_quadrant_out = quad_reg[QFSB_SIDE_FULL];
	assign empty_quadrant_out = quad_reg[QFSB_SIDE_EMPTY];

endmodule

// >>> design/qfsb_controller.sv
// Controller end: issues strobed quadrant selections in direct mode and
// collects the status buses, labelling each byte with its quadrant.
// Assumes the user holds queue selections off while a blocked flag is high.

module qfsb_controller import qfsb_pkg::*; (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic polled_mode_in,
	input wire logic full_sel_valid_in,
	input wire logic [2:0] full_sel_device_in,
	input wire logic [1:0] full_sel_quad_in,
	input wire logic empty_sel_valid_in,
	input wire logic [2:0] empty_sel_device_in,
	input wire logic [1:0] empty_sel_quad_in,
	output logic full_qsel_blocked_out,
	output logic empty_qsel_blocked_out,
	output logic [7:0] full_status_out,
	output logic [1:0] full_status_quad_out,
	output logic full_status_valid_out,
	output logic [7:0] empty_status_out,
	output logic [1:0] empty_status_quad_out,
	output logic empty_status_valid_out,
	qfsb_if.ctrl_mp link
);

	logic req_valid [QFSB_SIDES];
	logic [2:0] req_dev [QFSB_SIDES];
	logic [1:0] req_quad [QFSB_SIDES];
	logic [7:0] bus_in [QFSB_SIDES];
	logic bus_drv [QFSB_SIDES];
	logic bus_sync [QFSB_SIDES];

	always_comb begin
		req_valid[QFSB_SIDE_FULL] = full_sel_valid_in;
		req_dev[QFSB_SIDE_FULL] = full_sel_device_in;
		req_quad[QFSB_SIDE_FULL] = full_sel_quad_in;
		bus_in[QFSB_SIDE_FULL] = link.af_bus;
		bus_drv[QFSB_SIDE_FULL] = link.af_bus_oe;
		bus_sync[QFSB_SIDE_FULL] = link.af_sync;
		req_valid[QFSB_SIDE_EMPTY] = empty_sel_valid_in;
		req_dev[QFSB_SIDE_EMPTY] = empty_sel_device_in;
		req_quad[QFSB_SIDE_EMPTY] = empty_sel_quad_in;
		bus_in[QFSB_SIDE_EMPTY] = link.ae_bus;
		bus_drv[QFSB_SIDE_EMPTY] = link.ae_bus_oe;
		bus_sync[QFSB_SIDE_EMPTY] = link.ae_sync;
	end

	// ----------------------------------------------------------------
	// Selection issue and bus capture, one per bus
	// ----------------------------------------------------------------
	logic strobe_reg [QFSB_SIDES];
	logic [4:0] addr_reg [QFSB_SIDES];
	logic wait_reg [QFSB_SIDES];
	logic [1:0] wait_quad_reg [QFSB_SIDES];
	logic [7:0] stat_reg [QFSB_SIDES];
	logic [1:0] stat_quad_reg [QFSB_SIDES];
	logic stat_valid_reg [QFSB_SIDES];

	genvar s;
	generate
		for (s = 0; s < QFSB_SIDES; s++) begin : g_side
			logic strobe_next;
			logic [4:0] addr_next;
			logic wait_next;
			logic [1:0] wait_quad_next;
			logic [7:0] stat_next;
			logic [1:0] stat_quad_next;
			logic stat_valid_next;

			always_comb begin
				strobe_next = 1'b0;
				addr_next = addr_reg[s];
				wait_next = 1'b0;
				wait_quad_next = wait_quad_reg[s];
				stat_next = stat_reg[s];
				stat_quad_next = stat_quad_reg[s];
				stat_valid_next = 1'b0;
				if (!resetn_in) begin
					addr_next = 5'h00;
					wait_quad_next = QFSB_QUAD_RST;
					stat_next = QFSB_BUS_IDLE;
					stat_quad_next = QFSB_QUAD_RST;
				end else if (polled_mode_in) begin
					// Quadrant count restarts on each sync mark
					if (bus_drv[s]) begin
						stat_next = bus_in[s];
						stat_quad_next = bus_sync[s] ? QFSB_QUAD_RST :
							2'(stat_quad_reg[s] + 2'h1);
						stat_valid_next = 1'b1;
					end
				end else begin
					if (req_valid[s]) begin
						strobe_next = 1'b1;
						addr_next = {req_dev[s], req_quad[s]};
					end
					// Device takes the strobe this edge, new byte shows next cycle
					wait_next = strobe_reg[s];
					wait_quad_next = addr_reg[s][1:0];
					if (wait_reg[s]) begin
						stat_next = bus_in[s];
						stat_quad_next = wait_quad_reg[s];
						stat_valid_next = 1'b1;
					end
				end
			end

			always_ff @(posedge mclk_in) begin
				strobe_reg[s] <= strobe_next;
				addr_reg[s] <= addr_next;
				wait_reg[s] <= wait_next;
				wait_quad_reg[s] <= wait_quad_next;
				stat_reg[s] <= stat_next;
				stat_quad_reg[s] <= stat_quad_next;
				stat_valid_reg[s] <= stat_valid_next;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Link and user outputs
	// ----------------------------------------------------------------
	assign link.af_strobe = strobe_reg[QFSB_SIDE_FULL];
	assign link.wr_addr = {addr_reg[QFSB_SIDE_FULL][4:2], 3'h0, addr_reg[QFSB_SIDE_FULL][1:0]};
	assign link.ae_strobe = strobe_reg[QFSB_SIDE_EMPTY];
	assign link.rd_addr = {addr_reg[QFSB_SIDE_EMPTY][4:2], 2'h0, addr_reg[QFSB_SIDE_EMPTY][1:0]};
	// User must not select a queue while the strobe is out
	assign full_qsel_blocked_out = strobe_reg[QFSB_SIDE_FULL];
	assign empty_qsel_blocked_out = strobe_reg[QFSB_SIDE_EMPTY];
	assign full_status_out = stat_reg[QFSB_SIDE_FULL];
	assign full_status_quad_out = stat_quad_reg[QFSB_SIDE_FULL];
	assign full_status_valid_out = stat_valid_reg[QFSB_SIDE_FULL];
	assign empty_status_out = stat_reg[QFSB_SIDE_EMPTY];
	assign empty_status_quad_out = stat_quad_reg[QFSB_SIDE_EMPTY];
	assign empty_status_valid_out = stat_valid_reg[QFSB_SIDE_EMPTY];

endmodule

// >>> verification/qfsb_link_asserts.sv
// Link checker for both flag status buses of one device.
// Assumes one clock and the single device token loop in the interface.
module qfsb_link_asserts #(
	parameter logic [2:0] DEV_ID = 3'h0
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [7:0] wr_addr,
	input wire logic af_strobe,
	input wire logic [6:0] rd_addr,
	input wire logic ae_strobe,
	input wire logic af_bus_oe,
	input wire logic af_sync,
	input wire logic af_token_out,
	input wire logic ae_bus_oe,
	input wire logic ae_sync,
	input wire logic ae_token_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	// ----------------------------------------------------------------
	// Polled walk of four quadrants
	// ----------------------------------------------------------------
	sequence s_af_hold;
		af_bus_oe[*4];
	endsequence
	sequence s_af_pass;
		!af_token_out[*3] ##1 af_token_out;
	endsequence
	sequence s_ae_hold;
		ae_bus_oe[*4];
	endsequence
	sequence s_ae_pass;
		!ae_token_out[*3] ##1 ae_token_out;
	endsequence

	a_af_sync_hold: assert property (af_sync |-> s_af_hold)
		else $error("full bus released inside its four quadrants");
	a_af_token_pass: assert property (af_sync |-> s_af_pass)
		else $error("full bus token not given on last quadrant");
	a_af_sync_period: assert property (af_sync |=> !af_sync[*3] ##1 af_sync)
		else $error("full bus sync not every fourth cycle");
	a_ae_sync_hold: assert property (ae_sync |-> s_ae_hold)
		else $error("empty bus released inside its four quadrants");
	a_ae_token_pass: assert property (ae_sync |-> s_ae_pass)
		else $error("empty bus token not given on last quadrant");
	a_ae_sync_period: assert property (ae_sync |=> !ae_sync[*3] ##1 ae_sync)
		else $error("empty bus sync not every fourth cycle");

	// ----------------------------------------------------------------
	// Direct selection by identifier
	// ----------------------------------------------------------------
	a_af_strobe_mine: assert property (af_strobe && wr_addr[7:5] == DEV_ID |=> af_bus_oe)
		else $error("full bus not driven after own selection");
	a_af_strobe_other: assert property (af_strobe && wr_addr[7:5] != DEV_ID |=> !af_bus_oe)
		else $error("full bus still driven after foreign selection");
	a_ae_strobe_mine: assert property (ae_strobe && rd_addr[6:4] == DEV_ID |=> ae_bus_oe)
		else $error("empty bus not driven after own selection");
	a_ae_strobe_other: assert property (ae_strobe && rd_addr[6:4] != DEV_ID |=> !ae_bus_oe)
		else $error("empty bus still driven after foreign selection");
endmodule

// >>> verification/qfsb_status_bus_tb.sv
// Bench: device and controller joined by the link, against a cycle model.
// Assumes the interface loops each token back to the same device.
module qfsb_status_bus_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import qfsb_pkg::*;

	localparam logic [2:0] DEV_ID = 3'h5;
	logic mclk_in, resetn_in, mode, eight, mst;
	logic [1:0] rv, p1v, p2v, moe, pok, pv3;
	logic [5:0] rd;
	logic [3:0] rq;
	logic [2:0] p1d [2];
	logic [2:0] p2d [2];
	logic [1:0] p1q [2];
	logic [1:0] p2q [2];
	logic [1:0] mq [2];
	logic [1:0] pq [2];
	logic [7:0] pb [2];
	logic [31:0] st [2];
	logic [31:0] rng;
	wire polled;
	wire [1:0] bl, vl;
	wire [3:0] qo, dq;
	wire [15:0] so;
	int err_total, check_count, cyc, rcnt;

	qfsb_if qfsb_if_i ();

	qfsb_device qfsb_device_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.flag_bus_mode_select_in(mode), .chain_master_strap_in(mst),
		.device_identifier_bit0_in(DEV_ID[0]), .device_identifier_bit1_in(DEV_ID[1]),
		.device_identifier_bit2_in(DEV_ID[2]), .eight_or_fewer_queues_in(eight),
		.almost_full_status_in(st[0]), .almost_empty_status_in(st[1]),
		.polled_mode_out(polled), .full_quadrant_out(dq[1:0]),
		.empty_quadrant_out(dq[3:2]), .link(qfsb_if_i.device_mp));

	qfsb_controller qfsb_controller_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.polled_mode_in(mode), .full_sel_valid_in(rv[0]), .full_sel_device_in(rd[2:0]),
		.full_sel_quad_in(rq[1:0]), .empty_sel_valid_in(rv[1]),
		.empty_sel_device_in(rd[5:3]), .empty_sel_quad_in(rq[3:2]),
		.full_qsel_blocked_out(bl[0]), .empty_qsel_blocked_out(bl[1]),
		.full_status_out(so[7:0]), .full_status_quad_out(qo[1:0]),
		.full_status_valid_out(vl[0]), .empty_status_out(so[15:8]),
		.empty_status_quad_out(qo[3:2]), .empty_status_valid_out(vl[1]),
		.link(qfsb_if_i.ctrl_mp));

	qfsb_link_asserts #(.DEV_ID(DEV_ID)) qfsb_link_asserts_i (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .wr_addr(qfsb_if_i.wr_addr), .af_strobe(qfsb_if_i.af_strobe),
		.rd_addr(qfsb_if_i.rd_addr), .ae_strobe(qfsb_if_i.ae_strobe),
		.af_bus_oe(qfsb_if_i.af_bus_oe), .af_sync(qfsb_if_i.af_sync),
		.af_token_out(qfsb_if_i.af_token_out), .ae_bus_oe(qfsb_if_i.ae_bus_oe),
		.ae_sync(qfsb_if_i.ae_sync), .ae_token_out(qfsb_if_i.ae_token_out));

	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end

	// ----------------------------------------------------------------
	// Compare and closing
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// One cycle: model, compare, next request
	// ----------------------------------------------------------------
	task automatic step();
		logic [7:0] bus, xb;
		logic [31:0] r;
		@(negedge mclk_in);
		cyc++;
		rcnt++;
		chk1("mode", mode, polled);
		for (int s = 0; s < 2; s++) begin
			if (p2v[s] && !mode) begin
				moe[s] = p2d[s] == DEV_ID;
				if (moe[s]) mq[s] = p2q[s];
			end
			if (eight && !mode) begin
				mq[s] = 2'h0;
				moe[s] = 1'b1;
			end
			if (mode) begin
				mq[s] = mst ? 2'(rcnt - 1) : 2'h0;
				moe[s] = mst;
			end
			bus = s ? qfsb_if_i.ae_bus : qfsb_if_i.af_bus;
			xb = moe[s] ? 8'(st[s] >> {mq[s], 3'h0}) : 8'hff;
			if (cyc % 8 >= 2) chk8("bus", xb, bus);
			chk1("sync", moe[s] && mode && mq[s] == 2'h0,
				s ? qfsb_if_i.ae_sync : qfsb_if_i.af_sync);
			chk1("drive", moe[s], s ? qfsb_if_i.ae_bus_oe : qfsb_if_i.af_bus_oe);
			chk8("quad", {6'h0, mq[s]}, {6'h0, dq[s*2 +: 2]});
			chk1("blocked", p1v[s] && !mode, bl[s]);
			chk1("valid", mode ? (mst && rcnt >= 2) : pv3[s], vl[s]);
			if (vl[s] === 1'b1 && pok[s]) chk8("status", pb[s], so[s*8 +: 8]);
			if (vl[s] === 1'b1 && pok[s]) chk8("squad", {6'h0, pq[s]}, {6'h0, qo[s*2 +: 2]});
			pok[s] = cyc % 8 >= 2 && moe[s];
			pb[s] = xb;
			pq[s] = mq[s];
			pv3[s] = p2v[s];
			p2v[s] = p1v[s];
			p2d[s] = p1d[s];
			p2q[s] = p1q[s];
			r = rnd();
			p1v[s] = r[0] | r[1];
			p1d[s] = (r[4:3] == 2'h0 && !eight) ? r[7:5] : DEV_ID;
			// Quadrant 0 only when eight or fewer queues: nothing else is shown
			p1q[s] = eight ? 2'h0 : r[9:8];
			rv[s] = p1v[s];
			rd[s*3 +: 3] = p1d[s];
			rq[s*2 +: 2] = p1q[s];
		end
		if (cyc % 8 == 0) begin
			st[0] = rnd();
			st[1] = rnd();
		end
	endtask

	task automatic run(input logic m, input logic e, input logic ms, input int n);
		resetn_in = 1'b0;
		mode = m;
		eight = e;
		mst = ms;
		rv = 2'h0;
		p1v = 2'h0;
		p2v = 2'h0;
		pv3 = 2'h0;
		moe = 2'h0;
		pok = 2'h0;
		mq = '{2'h0, 2'h0};
		repeat (4) @(negedge mclk_in);
		resetn_in = 1'b1;
		rcnt = 0;
		repeat (n) step();
	endtask

	initial begin
		rng = 32'h00006e26;
		err_total = 0;
		check_count = 0;
		cyc = 0;
		rd = 6'h00;
		rq = 4'h0;
		st[0] = rnd();
		st[1] = rnd();
		run(1'b0, 1'b0, 1'b1, 400);
		run(1'b1, 1'b0, 1'b1, 64);
		run(1'b0, 1'b1, 1'b1, 48);
		run(1'b1, 1'b1, 1'b1, 32);
		run(1'b1, 1'b0, 1'b0, 24);
		run(1'b0, 1'b0, 1'b1, 40);
		test_done();
	end

	initial begin
		#100000;
		err_total++;
		test_done();
	end
endmodule
